// File: logic/pms_pkg.sv
// constants of the mouse link controller
package pms_pkg;
  localparam int unsigned CLK_NS       = 100;
  // inhibit must outlast one link clock period (slowest mouse near 100 us)
  localparam int unsigned INHIBIT_NS   = 120000;
  localparam int unsigned INHIBIT_CYC  = (INHIBIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned REQ_WAIT_MS  = 10;
  localparam int unsigned REQ_WAIT_CYC = REQ_WAIT_MS * 1000000 / CLK_NS;
  localparam int unsigned RX_IDLE_MS   = 2;
  localparam int unsigned RX_IDLE_CYC  = RX_IDLE_MS * 1000000 / CLK_NS;
  localparam int unsigned TMR_W        = 17;
  localparam int unsigned RPT_BITS     = 33;
  localparam int unsigned SLICE_BITS   = 11;
  localparam int unsigned TX_LAST_EDGE = 10;
  localparam int unsigned FIFO_DEPTH   = 4;
  localparam logic [5:0]  RX_LAST      = 6'h20;
  typedef enum logic [1:0] {ST_IDLE, ST_INH, ST_REQ, ST_TX} pms_state_t;
endpackage : pms_pkg

// File: logic/pms_link.sv
// mouse link controller: report fifo and link engine
`timescale 1ns/1ps
`default_nettype none

module pms_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
  logic             wr, rd;

  always_comb begin
    in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
    out_valid = wp_q != rp_q;
    out_data  = mem_q[rp_q[AW-1:0]];
    wr        = in_valid && in_ready;
    rd        = out_valid && out_ready;
    wp_d      = wr ? wp_q + 1'b1 : wp_q;
    rp_d      = rd ? rp_q + 1'b1 : rp_q;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    if (wr) mem_q[wp_q[AW-1:0]] <= in_data;
  end
endmodule : pms_fifo

// What this block and the mouse do
// [R1] two shared wires, clock and data; mouse clocks every transfer both ways
// [R2] mouse sends each report as one 33-bit frame
// [R3] frame is three slices: start 0, eight bits lsb first, odd parity, stop 1
// [R4] received data sampled on each falling edge of the mouse clock
// [R5] report gathered in 33-bit shift register from a synchronised clock
// [R6] send starts by holding clock low over one clock period; aborts reception
// [R7] then data driven low and clock released, forming the request
// [R8] mouse starts clocking within 10 ms of the request
// [R9] send spans start, eight data, odd parity, stop, acknowledge bits
// [R10] data line released after the parity bit
// [R11] mouse acknowledges by pulling data low
// [R12] mouse sends no reports until enabled by a command
// [R13] lines only pulled low or released, never driven high
// [R14] start, stop and odd parity of each slice checked; errors flagged
module pms_link
  import pms_pkg::*;
#(
  parameter int unsigned REQ_WAIT = REQ_WAIT_CYC,
  parameter int unsigned RX_IDLE  = RX_IDLE_CYC,
  parameter int unsigned DEPTH    = FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ps2_clk_i,
  output logic             ps2_clk_o,
  output logic             ps2_clk_oe,
  input  wire logic        ps2_dat_i,
  output logic             ps2_dat_o,
  output logic             ps2_dat_oe,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [7:0]  cmd_data,
  output logic             tx_done,
  output logic             tx_err,
  output logic             rpt_valid,
  input  wire logic        rpt_ready,
  output logic      [23:0] rpt_data,
  output logic             frame_err
);
  initial begin
    if (REQ_WAIT >= (1 << TMR_W) || RX_IDLE >= (1 << TMR_W) || REQ_WAIT < 2)
      $error("timeout parameter out of timer range");
  end

  function automatic logic odd_par(input logic [7:0] d);
    odd_par = ~^d;
  endfunction : odd_par

  function automatic logic slice_ok(input logic [10:0] s);
    slice_ok = !s[0] && s[10] && (s[9] == odd_par(s[8:1]));
  endfunction : slice_ok

  pms_state_t       st_q, st_d;
  logic [2:0]       ck_s_q, ck_s_d, dt_s_q, dt_s_d;
  logic             ck_f_q, ck_f_d, dt_f_q, dt_f_d, fall;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [5:0]       rx_cnt_q, rx_cnt_d;
  logic [32:0]      rx_sh_q, rx_sh_d, sh_n;
  logic [8:0]       tx_sh_q, tx_sh_d;
  logic [3:0]       edge_q, edge_d;
  logic             drv_q, drv_d;
  logic             done_q, done_d, err_q, err_d, ferr_q, ferr_d;
  logic             push, fifo_ready;

  always_comb begin
    // [R5] three-stage sync, edge counts once stages two and three agree
    ck_s_d = {ck_s_q[1:0], ps2_clk_i};
    dt_s_d = {dt_s_q[1:0], ps2_dat_i};
    ck_f_d = (ck_s_q[1] == ck_s_q[2]) ? ck_s_q[2] : ck_f_q;
    dt_f_d = (dt_s_q[1] == dt_s_q[2]) ? dt_s_q[2] : dt_f_q;
    fall   = ck_f_q && !ck_f_d;
    sh_n      = {dt_f_q, rx_sh_q[32:1]};
    st_d      = st_q;
    tmr_d     = (&tmr_q) ? tmr_q : tmr_q + 1'b1;
    rx_cnt_d  = rx_cnt_q;
    rx_sh_d   = rx_sh_q;
    tx_sh_d   = tx_sh_q;
    edge_d    = edge_q;
    drv_d     = drv_q;
    done_d    = 1'b0;
    err_d     = 1'b0;
    ferr_d    = 1'b0;
    push      = 1'b0;
    cmd_ready = st_q == ST_IDLE;
    unique case (st_q)
      ST_IDLE: begin
        if (cmd_valid) begin
          // [R6] a command aborts any partial report
          st_d     = ST_INH;
          tmr_d    = '0;
          rx_cnt_d = '0;
          tx_sh_d  = {odd_par(cmd_data), cmd_data};
        end else if (fall) begin
          // [R4] shift in on falling edge, lsb first
          rx_sh_d = sh_n;
          tmr_d   = '0;
          if (rx_cnt_q == RX_LAST) begin
            rx_cnt_d = '0;
            // [R14] all three slices checked before the report is kept
            if (slice_ok(sh_n[10:0]) && slice_ok(sh_n[21:11]) && slice_ok(sh_n[32:22]))
              push = 1'b1;
            else
              ferr_d = 1'b1;
          end else begin
            rx_cnt_d = rx_cnt_q + 1'b1;
          end
        end else if (rx_cnt_q != '0 && tmr_q >= TMR_W'(RX_IDLE)) begin
          // stalled frame would misalign every later report
          rx_cnt_d = '0;
          ferr_d   = 1'b1;
        end
      end
      ST_INH: begin
        // [R7] request: data low, clock released
        if (tmr_q == TMR_W'(INHIBIT_CYC - 1)) begin
          st_d   = ST_REQ;
          tmr_d  = '0;
          drv_d  = 1'b0;
          edge_d = '0;
        end
      end
      ST_REQ, ST_TX: begin
        if (fall) begin
          st_d    = ST_TX;
          tmr_d   = '0;
          edge_d  = edge_q + 1'b1;
          // [R9] data, parity, then ones fill so stop is the released line
          drv_d   = tx_sh_q[0];
          tx_sh_d = {1'b1, tx_sh_q[8:1]};
          if (edge_q == 4'(TX_LAST_EDGE)) begin
            st_d   = ST_IDLE;
            drv_d  = 1'b1;
            done_d = !dt_f_q;
            err_d  = dt_f_q;
          end
        end else if (tmr_q >= TMR_W'(REQ_WAIT)) begin
          // [R8] mouse silent past its limit
          st_d  = ST_IDLE;
          drv_d = 1'b1;
          err_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q     <= ST_IDLE;
      ck_s_q   <= 3'h7;
      dt_s_q   <= 3'h7;
      ck_f_q   <= 1'b1;
      dt_f_q   <= 1'b1;
      tmr_q    <= '0;
      rx_cnt_q <= '0;
      rx_sh_q  <= '0;
      tx_sh_q  <= '0;
      edge_q   <= '0;
      drv_q    <= 1'b1;
      done_q   <= 1'b0;
      err_q    <= 1'b0;
      ferr_q   <= 1'b0;
    end else begin
      st_q     <= st_d;
      ck_s_q   <= ck_s_d;
      dt_s_q   <= dt_s_d;
      ck_f_q   <= ck_f_d;
      dt_f_q   <= dt_f_d;
      tmr_q    <= tmr_d;
      rx_cnt_q <= rx_cnt_d;
      rx_sh_q  <= rx_sh_d;
      tx_sh_q  <= tx_sh_d;
      edge_q   <= edge_d;
      drv_q    <= drv_d;
      done_q   <= done_d;
      err_q    <= err_d;
      ferr_q   <= ferr_d;
    end
  end

  // [R13] open drain: only ever pull low
  assign ps2_clk_o  = 1'b0;
  assign ps2_dat_o  = 1'b0;
  // [R1] full fifo holds the clock low between frames so no report is lost
  assign ps2_clk_oe = (st_q == ST_INH) || (st_q == ST_IDLE && rx_cnt_q == '0 && !fifo_ready);
  // [R10] drv_q is one from the tenth edge on, so data is released
  assign ps2_dat_oe = (st_q == ST_REQ || st_q == ST_TX) && !drv_q;
  assign tx_done    = done_q;
  assign tx_err     = err_q;
  assign frame_err  = ferr_q;

  pms_fifo #(.WIDTH(24), .DEPTH(DEPTH)) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   ({sh_n[30:23], sh_n[19:12], sh_n[8:1]}),
    .out_valid (rpt_valid),
    .out_ready (rpt_ready),
    .out_data  (rpt_data)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence inh_to_req_s;
    st_q == ST_INH ##1 st_q == ST_REQ;
  endsequence
  sequence last_edge_s;
    st_q == ST_TX && edge_q == 4'(TX_LAST_EDGE) && fall;
  endsequence

  inhibit_hold_a: assert property (st_q == ST_INH |-> ps2_clk_oe && !ps2_dat_oe) // [R6]
    else $error("clock not held low during inhibit");
  inhibit_len_a: assert property (inh_to_req_s |-> $past(tmr_q) == TMR_W'(INHIBIT_CYC - 1)) // [R6]
    else $error("inhibit ended early");
  request_lines_a: assert property (inh_to_req_s |-> ps2_dat_oe && !ps2_clk_oe) // [R7]
    else $error("request state lines wrong");
  data_release_a: assert property (st_q == ST_TX && edge_q >= 4'(TX_LAST_EDGE) |-> !ps2_dat_oe) // [R10]
    else $error("data still driven after parity");
  tx_end_a: assert property (last_edge_s |=> st_q == ST_IDLE && (tx_done ^ tx_err)) // [R9]
    else $error("send did not finish on eleventh edge");
  drive_low_a: assert property (ps2_clk_oe || ps2_dat_oe |-> !ps2_clk_o && !ps2_dat_o) // [R13]
    else $error("line driven high");
  rx_shift_a: assert property (st_q == ST_IDLE && !cmd_valid && fall && rx_cnt_q < RX_LAST
      |=> rx_cnt_q == $past(rx_cnt_q) + 6'h01 && rx_sh_q[32] == $past(dt_f_q)) // [R4]
    else $error("falling edge not sampled");
  frame_end_a: assert property ($rose(frame_err) |-> $past(rx_cnt_q) == RX_LAST
      || $past(tmr_q) >= TMR_W'(RX_IDLE)) // [R14]
    else $error("frame error at wrong time");
  wait_limit_a: assert property (st_q == ST_REQ && !fall && tmr_q >= TMR_W'(REQ_WAIT)
      |=> st_q == ST_IDLE && tx_err) // [R8]
    else $error("request timeout missed");
endmodule : pms_link

`default_nettype wire

// File: tb/pms_mouse.sv
// behavioural mouse on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module pms_mouse (
  input  wire logic clk_line,
  input  wire logic dat_line,
  output logic      clk_pull,
  output logic      dat_pull
);
  logic enabled;
  initial begin
    clk_pull = 1'b0;
    dat_pull = 1'b0;
    enabled  = 1'b0;
  end
  // mouse clocks each bit, long low phase for the slow filter
  task automatic bit_out(input logic b);
    dat_pull = ~b;
    #100 clk_pull = 1'b1;
    #600 clk_pull = 1'b0;
    #100;
  endtask : bit_out
  // three slices lsb first; bad[0] breaks parity, bad[1] stop
  task automatic send_rpt(input logic [23:0] v, input logic [1:0] bad);
    // silent until a command is acknowledged
    if (!enabled) return;
    for (int n = 0; n < 2000 && !clk_line; n++) #100;
    for (int s = 0; s < 3; s++) begin
      bit_out(1'b0);
      for (int i = 0; i < 8; i++) bit_out(v[8*s+i]);
      bit_out(~^v[8*s+:8] ^ bad[0]);
      bit_out(~bad[1]);
    end
    dat_pull = 1'b0;
  endtask : send_rpt
  // cut frame: start bit, then ones, then the clock stops
  task automatic send_part(input int nbits);
    if (!enabled) return;
    for (int i = 0; i < nbits; i++) bit_out(i != 0);
    dat_pull = 1'b0;
  endtask : send_part
  // clock the command in, ack after the stop bit
  task automatic recv_cmd(input logic ack, output logic [9:0] got, output realtime inh);
    realtime t0;
    // bounded polls; a silent controller shows up as a missing command outcome
    for (int n = 0; n < 1000 && clk_line; n++) #1;
    t0 = $realtime;
    for (int n = 0; n < 200000 && !(clk_line && !dat_line); n++) #1;
    inh = $realtime - t0;
    #5000;
    for (int i = 0; i < 11; i++) begin
      // ack set up ahead of the last falling edge, as the filter lags
      if (i == 10) begin
        dat_pull = ack;
        #200;
      end
      clk_pull = 1'b1;
      #600 clk_pull = 1'b0;
      if (i < 10) got[i] = dat_line;
      #200;
    end
    dat_pull = 1'b0;
    if (ack) enabled = 1'b1;
  endtask : recv_cmd
endmodule : pms_mouse
`default_nettype wire

// File: tb/test_pms_link.sv
// self-checking bench for the mouse link controller
`timescale 1ns/1ps
`default_nettype none
module test_pms_link;
  import pms_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        rpt_ready = 1'b0;
  logic [7:0]  cmd_data = 8'h00;
  logic        clk_o, clk_oe, dat_o, dat_oe, cmd_ready, tx_done, tx_err;
  logic        rpt_valid, frame_err, m_clk, m_dat;
  logic [23:0] rpt_data;
  int          err_count = 0;
  int          num_checks = 0;
  // pull-ups: a released line reads high
  wire         clk_line = ~(clk_oe | m_clk);
  wire         dat_line = ~(dat_oe | m_dat);

  always #50 clk = ~clk;

  pms_link #(.REQ_WAIT(2000), .RX_IDLE(2000), .DEPTH(4)) i_dut (
    .clk(clk), .reset(reset), .ps2_clk_i(clk_line), .ps2_clk_o(clk_o),
    .ps2_clk_oe(clk_oe), .ps2_dat_i(dat_line), .ps2_dat_o(dat_o),
    .ps2_dat_oe(dat_oe), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_data(cmd_data), .tx_done(tx_done), .tx_err(tx_err),
    .rpt_valid(rpt_valid), .rpt_ready(rpt_ready), .rpt_data(rpt_data),
    .frame_err(frame_err));
  pms_mouse i_mouse (.clk_line(clk_line), .dat_line(dat_line), .clk_pull(m_clk),
    .dat_pull(m_dat));

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // bounded wait for the command outcome pulse
  task automatic issue(input logic [7:0] b, output logic [1:0] res);
    res = 2'b00;
    cmd_data = b;
    cmd_valid = 1'b1;
    step();
    cmd_valid = 1'b0;
    for (int n = 0; n < 6000 && res == 2'b00; n++) begin
      step();
      res = {tx_done, tx_err};
    end
    if (res == 2'b00) begin
      err_count++;
      $display("FAIL %0t no command outcome", $time);
      finish_test();
    end
  endtask : issue
  task automatic t_cmd(input logic ack, input logic [7:0] b);
    logic [9:0] got;
    logic [1:0] res;
    realtime    inh;
    check(cmd_ready, 1'b1, "ready");
    fork
      i_mouse.recv_cmd(ack, got, inh);
      issue(b, res);
    join
    check(got, {1'b1, ~^b, b}, "sent bits");
    check(inh >= INHIBIT_NS, 1'b1, "inhibit");
    check(res, {ack, ~ack}, "outcome");
    $display("command test done");
  endtask : t_cmd
  task automatic t_noclk();
    logic [1:0] res;
    issue(8'hA5, res);
    check(res, 2'b01, "no clock");
    check(dat_oe, 1'b0, "released");
    $display("silent mouse test done");
  endtask : t_noclk
  task automatic t_rpt();
    logic [23:0] v [4] = '{24'h0A0B0C, 24'hFF0080, 24'h000000, 24'h5A3C81};
    for (int i = 0; i < 4; i++) i_mouse.send_rpt(v[i], 2'b00);
    repeat (10) step();
    check(clk_oe, 1'b1, "stall");
    for (int i = 0; i < 4; i++) begin
      check({rpt_valid, rpt_data}, {1'b1, v[i]}, "report");
      rpt_ready = 1'b1;
      step();
      rpt_ready = 1'b0;
    end
    check(rpt_valid, 1'b0, "empty");
    $display("report test done");
  endtask : t_rpt
  task automatic t_bad(input logic [1:0] bad);
    int fe = 0;
    int rv = 0;
    rpt_ready = 1'b1;
    fork
      i_mouse.send_rpt(24'h123456, bad);
      repeat (400) begin
        step();
        fe += (frame_err === 1'b1);
        rv += (rpt_valid === 1'b1);
      end
    join
    check(fe, 1, "frame error");
    check(rv, 0, "dropped");
    $display("bad frame test done");
  endtask : t_bad
  task automatic t_cut();
    int fe = 0;
    rpt_ready = 1'b0;
    i_mouse.send_part(5);
    for (int n = 0; n < 2200; n++) begin
      step();
      fe += (frame_err === 1'b1);
    end
    check(fe, 1, "stalled frame");
    i_mouse.send_part(5);
    fork
      t_cmd(1'b1, 8'h5A);
      for (int n = 0; n < 1500; n++) begin
        step();
        fe += (frame_err === 1'b1);
      end
    join
    check(fe, 1, "aborted frame");
    i_mouse.send_rpt(24'hC3A51E, 2'b00);
    repeat (4) step();
    check({rpt_valid, rpt_data}, {1'b1, 24'hC3A51E}, "realigned");
    rpt_ready = 1'b1;
    step();
    rpt_ready = 1'b0;
    $display("cut frame test done");
  endtask : t_cut

  initial begin
    repeat (4) step();
    reset = 1'b0;
    check({clk_o, dat_o, clk_oe, dat_oe}, 4'h0, "idle");
    t_cmd(1'b1, 8'hF4);
    t_cmd(1'b0, 8'h3C);
    t_noclk();
    t_rpt();
    t_bad(2'b01);
    t_bad(2'b10);
    t_cut();
    finish_test();
  end
  // cut a hang short
  initial begin
    #3ms;
    err_count++;
    $display("FAIL %0t timeout", $time);
    finish_test();
  end
endmodule : test_pms_link
`default_nettype wire
